//--- bias_seq_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz aclk and an 8-bit AXI4-Lite byte address
`ifndef BIAS_SEQ_DEFINES_SVH
`define BIAS_SEQ_DEFINES_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CFG_OFF      8'h00
`define GANG_OFF     8'h04
`define SHORT_OFF    8'h08
`define STAT_OFF     8'h0c
`define APPL_OFF     8'h10
`define CFG_RST      16'h0000
`define GANG_RST     2'h0
`define SHORT_RST    4'h0
`define ST_BUSY      0
`define ST_OWNER     1
`define ST_SW        2
`define ST_ZERO      4
`define ST_SHORT     8
`define ST_STEP      12
`define APPL_GANG    16
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define SW_REMOTE    2'h0
`define SW_LOCAL     2'h1
`define SW_LOCKOUT   2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_NS       10
`define SETTLE_NS    1000000
`define LED_NS       50000000
`define SETTLE_CYC   ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define LED_CYC      ((`LED_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- bias_seq_pkg.sv
// types shared by the bias state change sequencer
// assumes nothing of its surroundings
package bias_seq_pkg;
    typedef struct packed {
        logic neg;
        logic ext_src;
        logic sweep;
        logic closed;
    } dev_cfg_s;
    typedef struct packed {
        logic [1:0] ctrl_src;
        logic       neg;
        logic       closed;
        logic       ext_src;
        logic       sum_sweep;
    } route_s;
    typedef enum logic [1:0] {
        GANG_NONE,
        GANG_PAIRS,
        GANG_ALL,
        GANG_RSVD
    } gang_e;
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_ZERO,
        SEQ_SHORT,
        SEQ_APPLY,
        SEQ_UNSHORT,
        SEQ_UNZERO
    } seq_state_e;
endpackage

//--- bias_sync.sv
// two-flop synchroniser for a bus of independent panel levels
// assumes each bit is a slow static level
`timescale 1ns/1ps
module bias_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = ce ? d : meta;
        next_q    = ce ? meta : q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

//--- settle_timer.sv
// settling timer: one done pulse COUNT+1 cycles after start
// comes out of reset already running so the reset sequence settles too
`timescale 1ns/1ps
module settle_timer #(
    parameter int unsigned COUNT = 1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic start,
    output logic      done
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        next_done;

    always_comb begin
        next_cnt  = cnt;
        next_done = 1'b0;
        if (start) begin
            next_cnt = COUNT;
        end else if (cnt != 32'h0) begin
            next_cnt  = cnt - 32'h1;
            next_done = (cnt == 32'h1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt  <= COUNT;
            done <= 1'b0;
        end else if (ce) begin
            cnt  <= next_cnt;
            done <= next_done;
        end
    end
endmodule

//--- bias_state_change_sequencer.sv
// four-device bias supply controller with protect sequencing
// assumes panel pins are asynchronous levels and the host is an
// AXI4-Lite master doing one write and one read at a time
//
// Notes on behaviour
// - every requested state change runs the full protect sequence
// - step one zeroes the amplifiers and shorts the integrating capacitor
// - step two shorts the bias source and monitor lines
// - step three applies the change while zeroed and shorted
// - step four releases the line shorts
// - last step releases the zeroing and the capacitor short
// - four independent device subsections, each separately controlled
// - ganging as two pairs or as all four devices
// - per-device polarity kept, also while ganged
// - one control and one external path, loop bit picks open or closed
// - one shared sweep source, enabled per device
// - sweep adds onto the preset bias as an offset
// - sweep is refused on a device using the external input
// - host may take control in remote or local switch position
// - lockout position refuses every host access
// - remote indicator lights when the host addresses the supply
`timescale 1ns/1ps
`include "bias_seq_defines.svh"
module bias_state_change_sequencer #(
    parameter int unsigned SETTLE_CYC = `SETTLE_CYC,
    parameter int unsigned LED_CYC    = `LED_CYC
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         ce,
    input  wire logic [7:0]                   awaddr,
    input  wire logic [2:0]                   awprot,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [7:0]                   araddr,
    input  wire logic [2:0]                   arprot,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    input  wire logic [15:0]                  panel_cfg,
    input  wire logic [1:0]                   panel_gang,
    input  wire logic [3:0]                   panel_short,
    input  wire logic [1:0]                   ctl_switch,
    output logic [3:0]                        amp_zero,
    output logic [3:0]                        line_short,
    output bias_seq_pkg::route_s [3:0]        dev_route,
    output logic                              remote_led
);
    // ----------------------------------------------------------------
    // panel inputs
    // ----------------------------------------------------------------
    logic [23:0] pan_q;
    logic [1:0]  sw;
    logic        lockout;

    bias_sync #(.W(24)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       ({ctl_switch, panel_short, panel_gang, panel_cfg}),
        .q       (pan_q)
    );

    assign sw      = pan_q[23:22];
    assign lockout = (sw == `SW_LOCKOUT);

    // ----------------------------------------------------------------
    // register slave
    // ----------------------------------------------------------------
    logic [7:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic [15:0] host_cfg;
    logic [1:0]  host_gang;
    logic [3:0]  host_short;
    logic        host_owner;
    logic [31:0] led_cnt;
    logic [31:0] stat;
    logic [31:0] appl;
    logic [31:0] rd_mux;
    logic        rd_map;
    logic        wr_map;
    logic        do_wr;
    logic        wr_ok;
    logic        rd_take;
    logic        rd_ok;
    logic [31:0] wr_val;
    logic [7:0]  next_aw_addr;
    logic        next_aw_held;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_w_held;
    logic [1:0]  next_bresp;
    logic        next_bvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_rvalid;
    logic [15:0] next_host_cfg;
    logic [1:0]  next_host_gang;
    logic [3:0]  next_host_short;
    logic        next_host_owner;
    logic [31:0] next_led_cnt;
    logic        next_remote_led;

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;
    assign do_wr   = aw_held && w_held && !bvalid;
    assign wr_map  = (aw_addr == `CFG_OFF) || (aw_addr == `GANG_OFF)
                  || (aw_addr == `SHORT_OFF);
    assign wr_ok   = wr_map && !lockout;
    assign rd_take = arvalid && arready;
    assign rd_map  = wr_map_rd(araddr);
    assign rd_ok   = rd_map && !lockout;

    function automatic logic wr_map_rd(input logic [7:0] a);
        wr_map_rd = (a == `CFG_OFF) || (a == `GANG_OFF)
                 || (a == `SHORT_OFF) || (a == `STAT_OFF)
                 || (a == `APPL_OFF);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    always_comb begin
        wr_val = 32'h0;
        case (aw_addr)
            `CFG_OFF:   wr_val = merge({16'h0, host_cfg}, w_data, w_strb);
            `GANG_OFF:  wr_val = merge({30'h0, host_gang}, w_data, w_strb);
            `SHORT_OFF: wr_val = merge({28'h0, host_short}, w_data, w_strb);
            default:    wr_val = 32'h0;
        endcase
    end

    always_comb begin
        rd_mux = 32'h0;
        case (araddr)
            `CFG_OFF:   rd_mux = {16'h0, host_cfg};
            `GANG_OFF:  rd_mux = {30'h0, host_gang};
            `SHORT_OFF: rd_mux = {28'h0, host_short};
            `STAT_OFF:  rd_mux = stat;
            `APPL_OFF:  rd_mux = appl;
            default:    rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        next_aw_addr    = aw_addr;
        next_aw_held    = aw_held;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_w_held     = w_held;
        next_bresp      = bresp;
        next_bvalid     = bvalid;
        next_rdata      = rdata;
        next_rresp      = rresp;
        next_rvalid     = rvalid;
        next_host_cfg   = host_cfg;
        next_host_gang  = host_gang;
        next_host_short = host_short;
        next_host_owner = host_owner;
        next_led_cnt    = (led_cnt != 32'h0) ? led_cnt - 32'h1 : led_cnt;
        if (awvalid && awready) begin
            next_aw_addr = awaddr;
            next_aw_held = 1'b1;
        end
        if (wvalid && wready) begin
            next_w_data = wdata;
            next_w_strb = wstrb;
            next_w_held = 1'b1;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_ok) begin
                next_host_owner = 1'b1;
                next_led_cnt    = LED_CYC;
                case (aw_addr)
                    `CFG_OFF:  next_host_cfg  = wr_val[15:0];
                    `GANG_OFF: next_host_gang = wr_val[1:0];
                    default:   next_host_short = wr_val[3:0];
                endcase
            end
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_ok ? rd_mux : 32'h0;
            next_rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (rd_ok) begin
                next_led_cnt = LED_CYC;
            end
        end
        if (lockout) begin
            next_host_owner = 1'b0;
        end
        next_remote_led = (next_led_cnt != 32'h0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr    <= 8'h00;
            aw_held    <= 1'b0;
            w_data     <= 32'h0;
            w_strb     <= 4'h0;
            w_held     <= 1'b0;
            bresp      <= `RESP_OKAY;
            bvalid     <= 1'b0;
            rdata      <= 32'h0;
            rresp      <= `RESP_OKAY;
            rvalid     <= 1'b0;
            host_cfg   <= `CFG_RST;
            host_gang  <= `GANG_RST;
            host_short <= `SHORT_RST;
            host_owner <= 1'b0;
            led_cnt    <= 32'h0;
            remote_led <= 1'b0;
        end else if (ce) begin
            aw_addr    <= next_aw_addr;
            aw_held    <= next_aw_held;
            w_data     <= next_w_data;
            w_strb     <= next_w_strb;
            w_held     <= next_w_held;
            bresp      <= next_bresp;
            bvalid     <= next_bvalid;
            rdata      <= next_rdata;
            rresp      <= next_rresp;
            rvalid     <= next_rvalid;
            host_cfg   <= next_host_cfg;
            host_gang  <= next_host_gang;
            host_short <= next_host_short;
            host_owner <= next_host_owner;
            led_cnt    <= next_led_cnt;
            remote_led <= next_remote_led;
        end
    end

    // ----------------------------------------------------------------
    // request selection
    // ----------------------------------------------------------------
    bias_seq_pkg::dev_cfg_s [3:0] src_cfg;
    bias_seq_pkg::dev_cfg_s [3:0] target;
    bias_seq_pkg::dev_cfg_s [3:0] applied;
    bias_seq_pkg::gang_e          target_gang;
    bias_seq_pkg::gang_e          applied_gang;
    logic [3:0]                   man_short;
    logic [3:0]                   chg;

    // host owns the request only while it holds control
    assign src_cfg     = host_owner ? host_cfg : pan_q[15:0];
    assign target_gang = bias_seq_pkg::gang_e'(host_owner ? host_gang
                                                          : pan_q[17:16]);
    assign man_short   = host_owner ? host_short : pan_q[21:18];

    for (genvar i = 0; i < 4; i++) begin : g_req
        always_comb begin
            target[i]       = src_cfg[i];
            target[i].sweep = src_cfg[i].sweep
                           && !src_cfg[i].ext_src;
            chg[i] = (target[i] != applied[i])
                  || (target_gang != applied_gang);
        end
    end

    // ----------------------------------------------------------------
    // protect sequencer
    // ----------------------------------------------------------------
    bias_seq_pkg::seq_state_e     state;
    bias_seq_pkg::seq_state_e     next_state;
    bias_seq_pkg::dev_cfg_s [3:0] next_applied;
    bias_seq_pkg::gang_e          next_applied_gang;
    logic [3:0]                   aff;
    logic [3:0]                   next_aff;
    logic [3:0]                   zero_q;
    logic [3:0]                   next_zero_q;
    logic [3:0]                   short_q;
    logic [3:0]                   next_short_q;
    logic                         step_done;
    logic                         step_start;

    settle_timer #(.COUNT(SETTLE_CYC)) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .start   (step_start),
        .done    (step_done)
    );

    // each step past idle restarts the settling interval
    assign step_start = (next_state != state)
                     && (next_state != bias_seq_pkg::SEQ_IDLE);

    always_comb begin
        next_state        = state;
        next_aff          = aff;
        next_zero_q       = zero_q;
        next_short_q      = short_q;
        next_applied      = applied;
        next_applied_gang = applied_gang;
        case (state)
            bias_seq_pkg::SEQ_IDLE: begin
                if (chg != 4'h0) begin
                    next_aff    = chg;
                    next_zero_q = zero_q | chg;
                    next_state  = bias_seq_pkg::SEQ_ZERO;
                end
            end
            bias_seq_pkg::SEQ_ZERO: begin
                if (step_done) begin
                    next_short_q = short_q | aff;
                    next_state   = bias_seq_pkg::SEQ_SHORT;
                end
            end
            bias_seq_pkg::SEQ_SHORT: begin
                if (step_done) begin
                    // only protected devices take their new state
                    for (int k = 0; k < 4; k++) begin
                        if (aff[k]) begin
                            next_applied[k] = target[k];
                        end
                    end
                    if (aff == 4'hf) begin
                        next_applied_gang = target_gang;
                    end
                    next_state        = bias_seq_pkg::SEQ_APPLY;
                end
            end
            bias_seq_pkg::SEQ_APPLY: begin
                if (step_done) begin
                    next_short_q = short_q & ~aff;
                    next_state   = bias_seq_pkg::SEQ_UNSHORT;
                end
            end
            bias_seq_pkg::SEQ_UNSHORT: begin
                if (step_done) begin
                    next_zero_q = zero_q & ~aff;
                    next_state  = bias_seq_pkg::SEQ_UNZERO;
                end
            end
            bias_seq_pkg::SEQ_UNZERO: begin
                if (step_done) begin
                    next_state = bias_seq_pkg::SEQ_IDLE;
                end
            end
            default: next_state = bias_seq_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= bias_seq_pkg::SEQ_APPLY;
            aff          <= 4'hf;
            zero_q       <= 4'hf;
            short_q      <= 4'hf;
            applied      <= `CFG_RST;
            applied_gang <= bias_seq_pkg::GANG_NONE;
        end else if (ce) begin
            state        <= next_state;
            aff          <= next_aff;
            zero_q       <= next_zero_q;
            short_q      <= next_short_q;
            applied      <= next_applied;
            applied_gang <= next_applied_gang;
        end
    end

    // ----------------------------------------------------------------
    // device outputs
    // ----------------------------------------------------------------
    bias_seq_pkg::route_s [3:0] next_route;
    logic [3:0]                 next_amp_zero;
    logic [3:0]                 next_line_short;

    for (genvar i = 0; i < 4; i++) begin : g_route
        always_comb begin
            case (applied_gang)
                bias_seq_pkg::GANG_PAIRS: next_route[i].ctrl_src =
                                              2'(i & 2);
                bias_seq_pkg::GANG_ALL:   next_route[i].ctrl_src = 2'h0;
                default:                  next_route[i].ctrl_src = 2'(i);
            endcase
            next_route[i].neg       = applied[i].neg;
            next_route[i].closed    = applied[i].closed;
            next_route[i].ext_src   = applied[i].ext_src;
            next_route[i].sum_sweep = applied[i].sweep;
        end
    end

    always_comb begin
        next_amp_zero   = next_zero_q;
        next_line_short = next_short_q | man_short;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_route  <= '0;
            amp_zero   <= 4'hf;
            line_short <= 4'hf;
        end else if (ce) begin
            dev_route  <= next_route;
            amp_zero   <= next_amp_zero;
            line_short <= next_line_short;
        end
    end

    // ----------------------------------------------------------------
    // status words
    // ----------------------------------------------------------------
    always_comb begin
        stat = 32'h0;
        stat[`ST_BUSY]          = (state != bias_seq_pkg::SEQ_IDLE);
        stat[`ST_OWNER]         = host_owner;
        stat[`ST_SW +: 2]       = sw;
        stat[`ST_ZERO +: 4]     = zero_q;
        stat[`ST_SHORT +: 4]    = short_q;
        stat[`ST_STEP +: 3]     = state;
        appl                    = 32'h0;
        appl[15:0]              = applied;
        appl[`APPL_GANG +: 2]   = applied_gang;
    end
endmodule

//--- bias_chk.sv
// checker: protect order, reset state and host answers
// assumes settle steps of at least 4 cycles and no manual shorts
`timescale 1ns/1ps
`include "bias_seq_defines.svh"
module bias_chk (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic                       bvalid,
    input wire logic                       bready,
    input wire logic [1:0]                 bresp,
    input wire logic [1:0]                 ctl_switch,
    input wire logic [3:0]                 amp_zero,
    input wire logic [3:0]                 line_short,
    input wire bias_seq_pkg::route_s [3:0] dev_route,
    input wire logic                       remote_led
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    for (genvar i = 0; i < 4; i++) begin : g_dev
        AST_ROUTE: assert property (
            $changed(dev_route[i]) |-> amp_zero[i] && line_short[i])
            else $error("route change while unprotected");
        AST_SHORT_LATE: assert property (
            $rose(line_short[i]) |-> amp_zero[i] && $past(amp_zero[i], 4))
            else $error("line short before zeroing");
        AST_UNSHORT: assert property (
            $fell(line_short[i]) |-> amp_zero[i] [*4])
            else $error("unzero too soon after unshort");
        AST_UNZERO: assert property (
            $fell(amp_zero[i]) |-> !line_short[i])
            else $error("unzero while lines shorted");
    end
    AST_RST: assert property (
        $rose(aresetn) |-> amp_zero == 4'hf && line_short == 4'hf)
        else $error("reset state not zeroed and shorted");
    AST_BHOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_LOCK: assert property (
        (ctl_switch == `SW_LOCKOUT) [*8] ##1 (bvalid && bready)
        |-> bresp == `RESP_SLVERR) else $error("lockout write accepted");
    AST_LED: assert property (
        bvalid && bready && bresp == `RESP_OKAY |-> ##[0:2] remote_led)
        else $error("indicator dark after host access");
endmodule
bind bias_state_change_sequencer bias_chk u_chk (.aclk, .aresetn,
    .bvalid, .bready, .bresp, .ctl_switch, .amp_zero, .line_short,
    .dev_route, .remote_led);

//--- bias_panel.sv
// panel model: operator switch and device levels
// assumes the bench moves the requests just after a clock edge
`timescale 1ns/1ps
module bias_panel (
    input  wire logic [1:0]  pos,
    input  wire logic [15:0] pcfg,
    output logic      [1:0]  ctl_switch,
    output logic      [15:0] panel_cfg
);
    assign ctl_switch = pos;
    assign panel_cfg  = pcfg;
endmodule

//--- bias_state_change_sequencer_bench.sv
// bench: host register traffic and protect sequencing checks
// assumes settle count 4, indicator count 8, 10 ns clock
`timescale 1ns/1ps
`include "bias_seq_defines.svh"
module bias_state_change_sequencer_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [2:0]  awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0, panel_short = 4'h0, amp_zero, line_short;
    logic [1:0]  pos = `SW_REMOTE, panel_gang = 2'h0;
    logic [1:0]  bresp, rresp, ctl_switch;
    logic [15:0] pcfg = 16'h0000, panel_cfg;
    logic        awready, wready, bvalid, arready, rvalid, remote_led;
    bias_seq_pkg::route_s [3:0] dev_route;
    logic [3:0]  rb [4] = '{4'ha, 4'h4, 4'h1, 4'h0};
    int          n_errors = 0;
    int          checks_done = 0;
    bit          seen;
    bias_state_change_sequencer #(.SETTLE_CYC(4), .LED_CYC(8)) dut (
        .aclk, .aresetn, .ce, .awaddr, .awprot, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .panel_cfg, .panel_gang, .panel_short, .ctl_switch,
        .amp_zero, .line_short, .dev_route, .remote_led);
    bias_panel panel (.pos, .pcfg, .ctl_switch, .panel_cfg);
    initial forever #5 aclk = ~aclk;
    // ----------------------------------------------------------------
    // host access, settle and tally tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(r), 32'(bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("rdata", d, rdata);
        chk("rresp", 32'(r), 32'(rresp));
    endtask
    // waits for a sequence to start and end, bounded
    task automatic settle();
        seen = 1'b0;
        for (int n = 0; n < 300 && !(seen && amp_zero === 4'h0); n++) begin
            @(posedge aclk);
            if (amp_zero !== 4'h0) seen = 1'b1;
        end
        chk("settle", 32'h1, 32'(seen && amp_zero === 4'h0));
        @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk("reset seq", 32'(seen), 32'h1);
        chk("lines", 32'(line_short), 32'h0);
        wr(`CFG_OFF, 32'h1e, 4'h1, `RESP_OKAY);
        settle();
        chk("seq run", 32'(seen), 32'h1);
        wr(`CFG_OFF, 32'h0200, 4'h2, `RESP_OKAY);
        settle();
        rd(`APPL_OFF, 32'h021c, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("led", 32'(remote_led), 32'h1);
        for (int g = 0; g < 4; g++) begin
            wr(`GANG_OFF, 32'(g), 4'hf, `RESP_OKAY);
            if (g != 0) settle();
            for (int i = 0; i < 4; i++)
                chk("route", 32'({2'(g == 1 ? i & 2 : (g == 2 ? 0 : i)),
                    rb[i]}), 32'(dev_route[i]));
        end
        pos <= `SW_LOCKOUT;
        pcfg <= 16'h0001;
        settle();
        wr(`CFG_OFF, 32'hffff, 4'hf, `RESP_SLVERR);
        rd(`CFG_OFF, 32'h0, `RESP_SLVERR);
        pos <= `SW_LOCAL;
        repeat (6) @(posedge aclk);
        rd(`APPL_OFF, 32'h0001, `RESP_OKAY);
        rd(`CFG_OFF, 32'h021e, `RESP_OKAY);
        rd(8'h14, 32'h0, `RESP_SLVERR);
        tally_and_finish();
    end
endmodule
